// [design/mb_front_pkg.sv]
package mb_front_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_FAST = 19200;
  localparam int BAUD_SLOW = 9600;
  localparam int OVS = 16;
  localparam int DIV_FAST = CLK_HZ / (BAUD_FAST * OVS);
  localparam int DIV_SLOW = CLK_HZ / (BAUD_SLOW * OVS);
  localparam int CHAR_BITS = 11;
  localparam int SIL_TENTHS = 35;
  localparam int SIL_TICKS = (SIL_TENTHS * CHAR_BITS * OVS + 9) / 10;
  localparam int IDLE_S = 30;
  localparam int IDLE_CYC_DEF = CLK_HZ * IDLE_S;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_NODE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_REQ = 8'h0C;
  localparam logic [7:0] OFF_ARG = 8'h10;
  localparam logic [7:0] OFF_TX = 8'h14;
  localparam logic [7:0] OFF_TEMP = 8'h18;
  localparam int CTL_RTU = 0;
  localparam int CTL_RS232 = 1;
  localparam int CTL_SLOW = 2;
  localparam int CTL_CONTACT = 3;
  localparam int CTL_REMOTE = 4;
  localparam int CTL_RUN = 5;
  localparam int TX_LAST = 8;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [5:0] NODE_RST = 6'h01;
  localparam logic [5:0] NODE_MIN = 6'h01;
  localparam logic [5:0] NODE_MAX = 6'h20;
  // ------------------------------------------------------------
  // Status codes
  // ------------------------------------------------------------
  localparam logic [15:0] ST_OK = 16'h8001;
  localparam logic [15:0] ST_COUNT = 16'h4801;
  localparam logic [15:0] ST_RANGE = 16'h4401;
  localparam logic [15:0] ST_FUNC = 16'h4201;
  localparam logic [15:0] ST_ADDR = 16'h0081;
  localparam logic [15:0] ST_CRC = 16'h0041;
  localparam logic [15:0] ST_LRC = 16'h0021;
  localparam logic [15:0] ST_CHAR = 16'h0001;
  localparam logic [15:0] ST_FAST = 16'h0002;
  localparam logic [15:0] ST_SHORT = 16'h0003;
  localparam logic [15:0] ST_NONE = 16'h0000;
  // ------------------------------------------------------------
  // Framing
  // ------------------------------------------------------------
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] FN_READ = 8'h04;
  localparam logic [7:0] FN_WR1 = 8'h06;
  localparam logic [7:0] FN_WRN = 8'h10;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int HDR_N = 9;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_NV = 3'b010,
    S_REPLY = 3'b100
  } link_state_e;
endpackage : mb_front_pkg

// [design/uart_char.sv]
`timescale 1ns/1ps
module uart_char #(
  parameter int DIV_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rxd,
  input wire logic i_slow,
  input wire logic i_eight,
  input wire logic i_tx_go,
  input wire logic [7:0] i_tx_byte,
  output logic [7:0] o_rx_byte,
  output logic o_rx_vld,
  output logic o_rx_err,
  output logic o_rx_busy,
  output logic o_tick,
  output logic o_txd,
  output logic o_tx_busy
);
  // ------------------------------------------------------------
  // Oversample divider
  // ------------------------------------------------------------
  localparam logic [DIV_W-1:0] LIM_F = DIV_W'(mb_front_pkg::DIV_FAST - 1);
  localparam logic [DIV_W-1:0] LIM_S = DIV_W'(mb_front_pkg::DIV_SLOW - 1);
  if (mb_front_pkg::DIV_SLOW > 2 ** DIV_W || mb_front_pkg::DIV_FAST < 2) begin : g_bad
    $error("uart_char: divider does not fit");
  end
  logic [DIV_W-1:0] div_ff;
  wire [DIV_W-1:0] lim = i_slow ? LIM_S : LIM_F;
  wire tick = (div_ff >= lim);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) div_ff <= '0;
    else div_ff <= tick ? '0 : div_ff + 1'b1;
  end
  assign o_tick = tick;
  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  logic s1_ff, s2_ff, rb_ff, vld_ff, err_ff;
  logic [3:0] rph_ff, ridx_ff;
  logic [9:0] rsh_ff;
  logic [7:0] rbyte_ff;
  wire [3:0] nbits = i_eight ? 4'd8 : 4'd7;
  wire samp = tick && rb_ff && (rph_ff == 4'd7);
  wire [9:0] nsh = {s2_ff, rsh_ff[9:1]};
  wire stop_now = samp && (ridx_ff == nbits + 4'd2);
  wire [7:0] rdat = i_eight ? nsh[7:0] : {1'b0, nsh[7:1]};
  wire par_bad = (^rdat) ^ nsh[8];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end else begin
      s1_ff <= i_rxd;
      s2_ff <= s1_ff;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rb_ff <= 1'b0;
      rph_ff <= '0;
      ridx_ff <= '0;
      rsh_ff <= '0;
    end else if (tick && !rb_ff && !s2_ff) begin
      rb_ff <= 1'b1;
      rph_ff <= '0;
      ridx_ff <= '0;
    end else if (tick && rb_ff) begin
      rph_ff <= rph_ff + 4'd1;
      if (samp) begin
        ridx_ff <= ridx_ff + 4'd1;
        if (ridx_ff == 4'd0) rb_ff <= !s2_ff;
        else rsh_ff <= nsh;
        if (stop_now) rb_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vld_ff <= 1'b0;
      err_ff <= 1'b0;
      rbyte_ff <= '0;
    end else begin
      vld_ff <= stop_now && nsh[9] && !par_bad;
      err_ff <= stop_now && (!nsh[9] || par_bad);
      if (stop_now) rbyte_ff <= rdat;
    end
  end
  assign o_rx_byte = rbyte_ff;
  assign o_rx_vld = vld_ff;
  assign o_rx_err = err_ff;
  assign o_rx_busy = rb_ff;
  // ------------------------------------------------------------
  // Transmitter, LSB first, even parity, one stop
  // ------------------------------------------------------------
  logic [10:0] tsh_ff;
  logic [3:0] tph_ff, tcnt_ff;
  logic tb_ff;
  wire [7:0] tdat = i_eight ? i_tx_byte : {1'b0, i_tx_byte[6:0]};
  wire [10:0] tload = i_eight ? {1'b1, ^tdat, tdat, 1'b0} : {2'b11, ^tdat, tdat[6:0], 1'b0};
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tsh_ff <= '1;
      tph_ff <= '0;
      tcnt_ff <= '0;
      tb_ff <= 1'b0;
    end else if (i_tx_go && !tb_ff) begin
      tsh_ff <= tload;
      tph_ff <= '0;
      tcnt_ff <= nbits + 4'd3;
      tb_ff <= 1'b1;
    end else if (tick && tb_ff) begin
      tph_ff <= tph_ff + 4'd1;
      if (tph_ff == 4'd15) begin
        tsh_ff <= {1'b1, tsh_ff[10:1]};
        tcnt_ff <= tcnt_ff - 4'd1;
        if (tcnt_ff == 4'd1) tb_ff <= 1'b0;
      end
    end
  end
  assign o_txd = tsh_ff[0];
  assign o_tx_busy = tb_ff;
endmodule : uart_char

// [design/modbus_front.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module modbus_front #(
  parameter int IDLE_CYC = mb_front_pkg::IDLE_CYC_DEF,
  parameter logic [15:0] REG_LAST = 16'h00FF,
  parameter logic [15:0] TEMP_REG = 16'h0040
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_tx_en,
  output logic o_rs232_sel,
  input wire logic i_contact_run,
  output logic o_run,
  output logic o_nv_write,
  output logic [15:0] o_nv_data,
  input wire logic i_nv_done,
  input wire logic [15:0] i_nv_value
);
  if (IDLE_CYC < 2 || TEMP_REG > REG_LAST) begin : g_bad
    $error("modbus_front: bad parameter");
  end
  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYC - 1);
  localparam logic [9:0] SIL_LAST = 10'(mb_front_pkg::SIL_TICKS);

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ mb_front_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_upd

  function automatic logic [4:0] hexval(input logic [7:0] c);
    logic [4:0] v;
    v = 5'h10;
    if (c >= 8'h30 && c <= 8'h39) v = {1'b0, 4'(c - 8'h30)};
    if (c >= 8'h41 && c <= 8'h46) v = {1'b0, 4'(c - 8'h37)};
    return v;
  endfunction : hexval

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [5:0] ctrl_ff, node_ff;
  logic [15:0] stat_ff, temp_ff;
  logic loaded_ff;
  wire rtu = ctrl_ff[mb_front_pkg::CTL_RTU];
  wire remote = ctrl_ff[mb_front_pkg::CTL_REMOTE];
  assign o_rs232_sel = ctrl_ff[mb_front_pkg::CTL_RS232];

  // ------------------------------------------------------------
  // Character engine
  // ------------------------------------------------------------
  logic [7:0] rx_byte;
  logic rx_vld, rx_err, rx_busy, tick, tx_busy, tx_go;
  logic [7:0] tx_byte;
  uart_char #(.DIV_W(8)) u_char (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rxd(i_rxd),
    .i_slow(ctrl_ff[mb_front_pkg::CTL_SLOW]),
    .i_eight(rtu),
    .i_tx_go(tx_go),
    .i_tx_byte(tx_byte),
    .o_rx_byte(rx_byte),
    .o_rx_vld(rx_vld),
    .o_rx_err(rx_err),
    .o_rx_busy(rx_busy),
    .o_tick(tick),
    .o_txd(o_txd),
    .o_tx_busy(tx_busy)
  );
  assign o_tx_en = tx_busy;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic dwr_ff;
  logic [7:0] dadr_ff;
  logic [31:0] rd_ff;
  mb_front_pkg::link_state_e st_ff;
  logic [7:0] fn_ff;
  logic [15:0] rg_ff, val_ff;
  wire aph = i_hsel && i_htrans[1] && i_hready;
  wire wr = dwr_ff;
  wire wr_ctrl = wr && dadr_ff == mb_front_pkg::OFF_CTRL;
  wire wr_node = wr && dadr_ff == mb_front_pkg::OFF_NODE;
  wire wr_tx = wr && dadr_ff == mb_front_pkg::OFF_TX;
  wire node_ok = i_hwdata[5:0] >= mb_front_pkg::NODE_MIN && i_hwdata[5:0] <= mb_front_pkg::NODE_MAX;
  wire [7:0] aoff = i_haddr[7:0];
  wire amap = i_haddr[31:8] == 24'h00_0000;
  wire reply = st_ff == mb_front_pkg::S_REPLY;
  wire [31:0] req_word = {21'h00_0000, st_ff == mb_front_pkg::S_NV, tx_busy, reply, fn_ff};
  wire [31:0] rd_mux =
    !amap ? 32'h0000_0000 :
    aoff == mb_front_pkg::OFF_CTRL ? {26'h000_0000, ctrl_ff} :
    aoff == mb_front_pkg::OFF_NODE ? {26'h000_0000, node_ff} :
    aoff == mb_front_pkg::OFF_STAT ? {16'h0000, stat_ff} :
    aoff == mb_front_pkg::OFF_REQ ? req_word :
    aoff == mb_front_pkg::OFF_ARG ? {val_ff, rg_ff} :
    aoff == mb_front_pkg::OFF_TEMP ? {16'h0000, temp_ff} :
    32'h0000_0000;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dwr_ff <= 1'b0;
      dadr_ff <= '0;
      rd_ff <= '0;
    end else begin
      dwr_ff <= aph && i_hwrite && amap;
      if (aph) dadr_ff <= aoff;
      if (aph && !i_hwrite) rd_ff <= rd_mux;
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rd_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_ff <= mb_front_pkg::CTRL_RST;
      node_ff <= mb_front_pkg::NODE_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= i_hwdata[5:0];
      if (wr_node && node_ok) node_ff <= i_hwdata[5:0];
    end
  end

  // ------------------------------------------------------------
  // Run/stop source
  // ------------------------------------------------------------
  logic c1_ff, c2_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      c1_ff <= 1'b0;
      c2_ff <= 1'b0;
    end else begin
      c1_ff <= i_contact_run;
      c2_ff <= c1_ff;
    end
  end
  assign o_run = ctrl_ff[mb_front_pkg::CTL_CONTACT] ? c2_ff : ctrl_ff[mb_front_pkg::CTL_RUN];

  // ------------------------------------------------------------
  // Frame assembly
  // ------------------------------------------------------------
  logic [7:0] hdr_ff [mb_front_pkg::HDR_N];
  logic [4:0] cnt_ff;
  logic [3:0] nib_ff;
  logic half_ff, inf_ff, cr_ff, bad_ff;
  logic [7:0] lrc_ff;
  logic [15:0] crc_ff;
  logic [9:0] sil_ff;
  wire idle = st_ff == mb_front_pkg::S_IDLE;
  wire take = rx_vld && idle;
  wire early = (rx_vld || rx_err) && !idle;
  wire [4:0] hx = hexval(rx_byte);
  wire is_colon = !rtu && rx_byte == mb_front_pkg::CH_COLON;
  wire is_cr = !rtu && inf_ff && rx_byte == mb_front_pkg::CH_CR;
  wire is_lf = !rtu && inf_ff && cr_ff && rx_byte == mb_front_pkg::CH_LF;
  wire a_hex = take && !rtu && inf_ff && !cr_ff && !hx[4];
  wire a_junk = take && !rtu && inf_ff && !is_colon && !is_lf && !is_cr && hx[4];
  wire app = rtu ? take : (a_hex && half_ff);
  wire [7:0] app_b = rtu ? rx_byte : {nib_ff, hx[3:0]};
  wire fe_a = take && is_lf;
  wire fe_r = rtu && cnt_ff != 5'd0 && sil_ff == SIL_LAST;
  wire fe = fe_a || fe_r;
  wire clr = fe || (take && is_colon);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
      nib_ff <= '0;
      half_ff <= 1'b0;
      inf_ff <= 1'b0;
      cr_ff <= 1'b0;
      bad_ff <= 1'b0;
      lrc_ff <= '0;
      crc_ff <= mb_front_pkg::CRC_INIT;
      sil_ff <= '0;
    end else begin
      if (rx_busy || rx_vld) sil_ff <= '0;
      else if (tick && sil_ff != SIL_LAST) sil_ff <= sil_ff + 10'd1;
      if (clr) begin
        cnt_ff <= '0;
        half_ff <= 1'b0;
        cr_ff <= 1'b0;
        bad_ff <= 1'b0;
        lrc_ff <= '0;
        crc_ff <= mb_front_pkg::CRC_INIT;
        inf_ff <= take && is_colon;
      end else begin
        if (rx_err && idle) bad_ff <= 1'b1;
        if (a_junk) bad_ff <= 1'b1;
        if (take && is_cr) cr_ff <= 1'b1;
        if (a_hex) begin
          half_ff <= !half_ff;
          nib_ff <= hx[3:0];
        end
        if (app) begin
          if (cnt_ff != 5'd31) cnt_ff <= cnt_ff + 5'd1;
          lrc_ff <= lrc_ff + app_b;
          crc_ff <= crc_upd(crc_ff, app_b);
        end
      end
    end
  end
  for (genvar i = 0; i < mb_front_pkg::HDR_N; i++) begin : g_hdr
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) hdr_ff[i] <= '0;
      else if (app && !clr && cnt_ff == 5'(i)) hdr_ff[i] <= app_b;
    end
  end

  // ------------------------------------------------------------
  // Request evaluation
  // ------------------------------------------------------------
  wire [4:0] pl = rtu ? cnt_ff - 5'd2 : cnt_ff - 5'd1;
  wire short_f = cnt_ff < 5'd4 || bad_ff || half_ff;
  wire chk_ok = rtu ? crc_ff == 16'h0000 : lrc_ff == 8'h00;
  wire [7:0] fn = hdr_ff[1];
  wire [15:0] rg = {hdr_ff[2], hdr_ff[3]};
  wire [15:0] arg = {hdr_ff[4], hdr_ff[5]};
  wire f_rd = fn == mb_front_pkg::FN_READ;
  wire f_w1 = fn == mb_front_pkg::FN_WR1;
  wire f_wn = fn == mb_front_pkg::FN_WRN;
  wire [15:0] qty = f_w1 ? 16'h0001 : arg;
  wire [8:0] wn_len = 9'd7 + {1'b0, hdr_ff[6]};
  wire cnt_ok = f_wn ? ({4'h0, pl} == wn_len && {8'h00, hdr_ff[6]} == {qty[14:0], 1'b0} && qty != 16'h0000)
                     : (pl == 5'd6 && qty != 16'h0000);
  wire [16:0] top = {1'b0, rg} + {1'b0, qty} - 17'd1;
  wire rng_ok = top <= {1'b0, REG_LAST};
  wire wr_req = f_w1 || f_wn;
  wire wr_ok = rg == TEMP_REG && qty == 16'h0001 && remote;
  wire [15:0] wdat = f_w1 ? arg : {hdr_ff[7], hdr_ff[8]};
  wire [15:0] code =
    short_f ? mb_front_pkg::ST_SHORT :
    !chk_ok ? (rtu ? mb_front_pkg::ST_CRC : mb_front_pkg::ST_LRC) :
    hdr_ff[0] != {2'b00, node_ff} ? mb_front_pkg::ST_ADDR :
    !(f_rd || wr_req) ? mb_front_pkg::ST_FUNC :
    !cnt_ok ? mb_front_pkg::ST_COUNT :
    !rng_ok || (wr_req && !wr_ok) ? mb_front_pkg::ST_RANGE :
    mb_front_pkg::ST_OK;
  wire silent = short_f || !chk_ok || hdr_ff[0] != {2'b00, node_ff};
  wire do_wr = code == mb_front_pkg::ST_OK && wr_req;
  wire changed = wdat != temp_ff;

  // ------------------------------------------------------------
  // Link sequencer
  // ------------------------------------------------------------
  logic nvw_ff, txlast_ff;
  logic [IW-1:0] idle_ff;
  assign tx_go = wr_tx && reply && !tx_busy && !rx_busy;
  assign tx_byte = i_hwdata[7:0];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= mb_front_pkg::S_IDLE;
      fn_ff <= '0;
      rg_ff <= '0;
      val_ff <= '0;
      nvw_ff <= 1'b0;
      txlast_ff <= 1'b0;
    end else begin
      nvw_ff <= 1'b0;
      unique case (st_ff)
        mb_front_pkg::S_IDLE: begin
          if (fe && !silent) begin
            fn_ff <= fn;
            rg_ff <= rg;
            val_ff <= f_wn ? wdat : arg;
            txlast_ff <= 1'b0;
            if (do_wr && changed) begin
              nvw_ff <= 1'b1;
              st_ff <= mb_front_pkg::S_NV;
            end else begin
              st_ff <= mb_front_pkg::S_REPLY;
            end
          end
        end
        mb_front_pkg::S_NV: begin
          if (i_nv_done) st_ff <= mb_front_pkg::S_REPLY;
        end
        mb_front_pkg::S_REPLY: begin
          if (tx_go) txlast_ff <= i_hwdata[mb_front_pkg::TX_LAST];
          if (txlast_ff && !tx_busy) st_ff <= mb_front_pkg::S_IDLE;
        end
      endcase
    end
  end
  assign o_nv_write = nvw_ff;

  // ------------------------------------------------------------
  // Stored set temperature
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      temp_ff <= '0;
      loaded_ff <= 1'b0;
    end else if (!loaded_ff) begin
      temp_ff <= i_nv_value;
      loaded_ff <= 1'b1;
    end else if (idle && fe && !silent && do_wr && changed) begin
      temp_ff <= wdat;
    end
  end
  assign o_nv_data = temp_ff;

  // ------------------------------------------------------------
  // Communication status
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_ff <= mb_front_pkg::ST_NONE;
      idle_ff <= '0;
    end else if (idle && fe) begin
      stat_ff <= code;
      idle_ff <= '0;
    end else if (early) begin
      stat_ff <= mb_front_pkg::ST_FAST;
    end else if (rx_err) begin
      stat_ff <= mb_front_pkg::ST_CHAR;
    end else if (idle_ff == IDLE_LAST) begin
      stat_ff <= mb_front_pkg::ST_NONE;
    end else begin
      idle_ff <= idle_ff + 1'b1;
    end
  end
endmodule : modbus_front

// [tb/mb_front_asserts.sv]
`timescale 1ns/1ps
module mb_front_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic o_tx_en,
  input wire logic o_rs232_sel,
  input wire logic o_nv_write,
  input wire logic [15:0] o_nv_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic ctl_wr_ff;
  wire take = i_hsel && i_htrans[1] && i_hready;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) ctl_wr_ff <= 1'b0;
    else ctl_wr_ff <= take && i_hwrite && i_haddr[7:0] == 8'h00;
  end
  sequence rd_taken;
    take && !i_hwrite;
  endsequence
  a_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("Bus not ready or not okay");
  a_unmapped_zero: assert property (rd_taken ##0 i_haddr[7:0] >= 8'h1C |=> o_hrdata == 32'h0)
    else $error("Unmapped read not zero");
  a_rdata_hold: assert property (!(take && !i_hwrite) |=> $stable(o_hrdata)) else $error("Read data moved");
  a_sel_follows: assert property (ctl_wr_ff |=> o_rs232_sel == $past(i_hwdata[1]))
    else $error("Line select not updated");
  a_nv_single: assert property (o_nv_write |=> !o_nv_write) else $error("Commit pulse too long");
  a_nv_commit: assert property ($changed(o_nv_data) && !$past(i_rst, 2) |-> o_nv_write)
    else $error("Stored value changed without commit");
  a_tx_idle_high: assert property (!o_tx_en |-> o_txd) else $error("Line not idle");
  a_half_duplex: assert property (o_tx_en |-> i_rxd) else $error("Sending during request");
endmodule : mb_front_asserts
bind modbus_front mb_front_asserts mb_front_asserts_inst (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_rxd(i_rxd), .o_txd(o_txd),
  .o_tx_en(o_tx_en), .o_rs232_sel(o_rs232_sel), .o_nv_write(o_nv_write), .o_nv_data(o_nv_data));

// [tb/host_model.sv]
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk,
  output logic o_rxd
);
  localparam int BIT_CYC = mb_front_pkg::DIV_FAST * mb_front_pkg::OVS;
  initial o_rxd = 1'b1;
  function automatic logic [15:0] crc16(input logic [7:0] m[$]);
    logic [15:0] c;
    c = mb_front_pkg::CRC_INIT;
    foreach (m[i]) begin
      c = c ^ {8'h00, m[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ mb_front_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16
  task automatic send_char(input logic [7:0] b);
    logic [10:0] frm;
    frm = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge i_clk);
      o_rxd <= frm[i];
      repeat (BIT_CYC - 1) @(posedge i_clk);
    end
  endtask : send_char
  task automatic send_rtu(input logic [7:0] m[$]);
    logic [15:0] c;
    c = crc16(m);
    m.push_back(c[7:0]);
    m.push_back(c[15:8]);
    foreach (m[i]) send_char(m[i]);
  endtask : send_rtu
endmodule : host_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, hsel, hwrite, contact, nv_done, nv_seen, rxd, rdy, resp, txd, tx_en, rs232, run, nv_wr;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] nv_data;
  logic [15:0] nv_init = 16'h00D0;
  logic [7:0] req[$];
  int bad_count, comparisons, nv_cnt, tx_cnt;
  modbus_front #(.IDLE_CYC(12000)) modbus_front_inst (.i_clk(clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
    .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(hrdata), .i_rxd(rxd), .o_txd(txd),
    .o_tx_en(tx_en), .o_rs232_sel(rs232), .i_contact_run(contact), .o_run(run), .o_nv_write(nv_wr),
    .o_nv_data(nv_data), .i_nv_done(nv_done), .i_nv_value(nv_init));
  host_model host_model_inst (.i_clk(clk), .o_rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) begin
    nv_seen <= nv_wr;
    nv_cnt += nv_wr;
    tx_cnt += tx_en;
  end
  always @(posedge clk) nv_done <= nv_seen;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    {rst, hsel, contact, nv_done, nv_seen, hwrite, htrans, haddr, hwdata} = {2'b11, 70'h0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h04, 32'h0000_0001);
    rdchk(8'h08, 32'h0000_0000);
    rdchk(8'h18, 32'h0000_00D0);
    rdchk(8'h1C, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0000_0021);
    rdchk(8'h04, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_0020);
    rdchk(8'h04, 32'h0000_0020);
    bus(1'b1, 8'h04, 32'h0000_0001);
    bus(1'b1, 8'h00, 32'h0000_000B);
    contact <= 1'b1;
    repeat (4) @(posedge clk);
    check(run, 1'b1);
    check(rs232, 1'b1);
    contact <= 1'b0;
    repeat (4) @(posedge clk);
    check(run, 1'b0);
    bus(1'b1, 8'h00, 32'h0000_0031);
    @(posedge clk);
    check(run, 1'b1);
    $display("test settings done");
    req = '{8'h01, 8'h06, 8'h00, 8'h40, 8'h00, 8'hEA};
    host_model_inst.send_rtu(req);
    rd = 32'h0000_0000;
    for (int i = 0; i < 15000 && rd[8] !== 1'b1; i++) bus(1'b0, 8'h0C, 32'h0000_0000);
    check(rd[10:0], 11'h106);
    rdchk(8'h08, 32'h0000_8001);
    rdchk(8'h18, 32'h0000_00EA);
    check(nv_cnt, 1);
    check(nv_data, 16'h00EA);
    check(tx_cnt, 0);
    $display("test frame done");
    bus(1'b1, 8'h14, 32'h0000_0101);
    repeat (7000) @(posedge clk);
    check(tx_cnt > 0, 1'b1);
    bus(1'b0, 8'h0C, 32'h0000_0000);
    check(rd[9:8], 2'b00);
    rdchk(8'h08, 32'h0000_8001);
    repeat (12000) @(posedge clk);
    rdchk(8'h08, 32'h0000_0000);
    $display("test reply done");
    give_verdict();
  end
endmodule : tb_top
